// ==== msg_pending_pkg.sv ====
// Constants and state encodings for the message pending alert block
// Behaviour
// - Open-drain active-low alert pulls low while a new message waits.
// - Alert stays low while at least one unread message is queued; the code releases it from ack and staging until STOP.
// - Release after identifier byte acknowledged and next byte staged.
// - On STOP, stay released if queue empty, else pull low again.
// - Identifier 255 signals no valid message; host ends reading there.
// - NACK then STOP resets address pointer to message count object.
// - Identifier 38h..47h names touch contacts one to sixteen.
package msg_pending_pkg;
   localparam logic [7:0]  END_IDENT     = 8'hFF;    // No valid message left
   localparam logic [7:0]  TOUCH_ID_BASE = 8'h38;    // First touch identifier
   localparam logic [7:0]  TOUCH_ID_LAST = 8'h47;    // Sixteenth touch identifier
   localparam logic [15:0] COUNT_ADDR    = 16'h0182; // Pending count object
   localparam int          EV_N          = 4;        // Link event count
   localparam int          EV_ACK        = 0;        // Identifier byte acked
   localparam int          EV_STAGED     = 1;        // Next byte in buffer
   localparam int          EV_NACK       = 2;        // Host NACK on a byte
   localparam int          EV_STOP       = 3;        // STOP condition

   typedef enum logic [1:0]
   {
      ST_IDLE     = 2'b00, // Released, nothing queued
      ST_ALERT    = 2'b01, // Pulled low, waiting for identifier ack
      ST_ACKED    = 2'b10, // Identifier acked, waiting for staging
      ST_RELEASED = 2'b11  // Released until the transfer stops
   } alert_state_t;
endpackage : msg_pending_pkg

// ==== message_pending_signal.sv ====
// Alert line controller with link event crossing and pointer reset
`timescale 1ns/1ns
`default_nettype none
module message_pending_signal
(
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   input  wire logic        link_clk_i,
   input  wire logic        id_ack_i,
   input  wire logic        next_staged_i,
   input  wire logic        nack_i,
   input  wire logic        stop_i,
   input  wire logic [7:0]  msg_count_i,
   input  wire logic [3:0]  touch_idx_i,
   output var  logic        message_pending_n_o,
   output var  logic        message_pending_n_oe_o,
   output var  logic [7:0]  message_identifier_o,
   output var  logic [15:0] ptr_addr_o,
   output var  logic        ptr_reset_o
);
   localparam int N = msg_pending_pkg::EV_N;

   // Link side state: one toggle per event
   typedef struct packed
   {
      logic [N-1:0] tog;
   } link_state_t;

   // Controller side state
   typedef struct packed
   {
      logic [N-1:0]                sync1;
      logic [N-1:0]                sync2;
      logic [N-1:0]                sync3;
      msg_pending_pkg::alert_state_t st;
      logic                        drv_lvl;
      logic                        oe;
      logic [7:0]                  ident;
      logic [15:0]                 ptr;
      logic                        ptr_rst;
      logic                        nack_seen;
   } core_state_t;

   link_state_t l_r;
   link_state_t l_nxt;
   core_state_t c_r;
   core_state_t c_nxt;
   logic        rst_n;
   logic [N-1:0] ev_in;
   logic [N-1:0] ev;

   // Synchronised reset copy; release passes two flops
   logic [1:0] rsync_r;
   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rsync_r <= 2'b00;
      else
         rsync_r <= {rsync_r[0], 1'b1};
   end
   assign rst_n = rsync_r[1];

   // Link reset is the raw pin; link clock may stand still outside frames
   assign ev_in = {stop_i, nack_i, next_staged_i, id_ack_i};

   // Events become toggles so a pulse survives the slower or stopped clock
   generate
      for (genvar i = 0; i < N; i++)
      begin : g_tog
         assign l_nxt.tog[i] = l_r.tog[i] ^ ev_in[i];
      end
   endgenerate

   always_ff @(posedge link_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         l_r <= '0;
      else
         l_r <= l_nxt;
   end

   // Edge of each synchronised toggle is one event in controller time
   assign ev = c_r.sync2 ^ c_r.sync3;

   // Controller next state
   always_comb
   begin
      c_nxt          = c_r;
      c_nxt.sync1    = l_r.tog;
      c_nxt.sync2    = c_r.sync1;
      c_nxt.sync3    = c_r.sync2;
      c_nxt.drv_lvl  = 1'b0;
      c_nxt.ptr_rst  = 1'b0;
      // Identifier shown to the link engine
      if (msg_count_i == 8'h00)
         c_nxt.ident = msg_pending_pkg::END_IDENT;
      else
         c_nxt.ident = msg_pending_pkg::TOUCH_ID_BASE + {4'h0, touch_idx_i};
      // NACK remembered until STOP decides whether pointer resets
      if (ev[msg_pending_pkg::EV_NACK])
         c_nxt.nack_seen = 1'b1;
      if (ev[msg_pending_pkg::EV_STOP])
      begin
         c_nxt.nack_seen = 1'b0;
         if (c_r.nack_seen || ev[msg_pending_pkg::EV_NACK])
         begin
            c_nxt.ptr     = msg_pending_pkg::COUNT_ADDR;
            c_nxt.ptr_rst = 1'b1;
         end
      end
      case (c_r.st)
         msg_pending_pkg::ST_IDLE:
         begin
            if (msg_count_i != 8'h00)
               c_nxt.st = msg_pending_pkg::ST_ALERT;
         end
         msg_pending_pkg::ST_ALERT:
         begin
            // Ack and staging landing in one cycle release at once
            if (ev[msg_pending_pkg::EV_STAGED] && ev[msg_pending_pkg::EV_ACK])
               c_nxt.st = msg_pending_pkg::ST_RELEASED;
            else if (ev[msg_pending_pkg::EV_ACK])
               c_nxt.st = msg_pending_pkg::ST_ACKED;
            else if (msg_count_i == 8'h00)
               c_nxt.st = msg_pending_pkg::ST_IDLE;
         end
         msg_pending_pkg::ST_ACKED:
         begin
            if (ev[msg_pending_pkg::EV_STAGED])
               c_nxt.st = msg_pending_pkg::ST_RELEASED;
         end
         msg_pending_pkg::ST_RELEASED:
         begin
            // STOP re-evaluates the queue; bytes in between never pull low
            if (ev[msg_pending_pkg::EV_STOP])
               c_nxt.st = (msg_count_i != 8'h00) ? msg_pending_pkg::ST_ALERT
                                                 : msg_pending_pkg::ST_IDLE;
         end
         default:
            c_nxt.st = msg_pending_pkg::ST_IDLE;
      endcase
      // A STOP while acked, before release, still ends the message cycle cleanly
      if (ev[msg_pending_pkg::EV_STOP] && c_r.st == msg_pending_pkg::ST_ACKED)
         c_nxt.st = (msg_count_i != 8'h00) ? msg_pending_pkg::ST_ALERT
                                           : msg_pending_pkg::ST_IDLE;
      c_nxt.oe = (c_nxt.st == msg_pending_pkg::ST_ALERT) ||
                 (c_nxt.st == msg_pending_pkg::ST_ACKED);
   end

   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         c_r       <= '0;
         c_r.ident <= msg_pending_pkg::END_IDENT;
         c_r.ptr   <= msg_pending_pkg::COUNT_ADDR;
         c_r.st    <= msg_pending_pkg::ST_IDLE;
      end
      else
         c_r <= c_nxt;
   end

   // Outputs straight from flops; pin level is always low, enable pulls
   assign message_pending_n_o    = c_r.drv_lvl;
   assign message_pending_n_oe_o = c_r.oe;
   assign message_identifier_o   = c_r.ident;
   assign ptr_addr_o             = c_r.ptr;
   assign ptr_reset_o            = c_r.ptr_rst;

   // Checks
   sequence ack_seen_s;
      ev[msg_pending_pkg::EV_ACK] && c_r.st == msg_pending_pkg::ST_ALERT;
   endsequence

   sequence staged_seen_s;
      ev[msg_pending_pkg::EV_STAGED] && !ev[msg_pending_pkg::EV_STOP];
   endsequence

   sequence acked_s;
      c_r.st == msg_pending_pkg::ST_ACKED;
   endsequence

   // NACK earlier or in the same cycle pairs with this STOP
   sequence nack_stop_s;
      ev[msg_pending_pkg::EV_STOP] && (c_r.nack_seen || ev[msg_pending_pkg::EV_NACK]);
   endsequence

   alert_enable_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      c_r.oe |-> (c_r.st == msg_pending_pkg::ST_ALERT || c_r.st == msg_pending_pkg::ST_ACKED))
      else $error("alert enabled outside alert states");

   pending_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (c_r.st == msg_pending_pkg::ST_IDLE && msg_count_i != 8'h00) |=> c_r.oe)
      else $error("queued message did not pull alert low");

   release_seq_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (acked_s ##0 staged_seen_s) |=> !c_r.oe)
      else $error("alert not released after ack and staging");

   ack_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (ack_seen_s ##0 !ev[msg_pending_pkg::EV_STAGED]) |=> (c_r.oe && c_r.st == msg_pending_pkg::ST_ACKED))
      else $error("identifier ack did not hold alert");

   release_pair_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (ack_seen_s ##0 ev[msg_pending_pkg::EV_STAGED]) |=> !c_r.oe)
      else $error("ack with staging did not release alert");

   hold_until_staged_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (c_r.st == msg_pending_pkg::ST_ACKED && ev == '0) |=> c_r.oe)
      else $error("alert released before next byte staged");

   stop_again_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (c_r.st == msg_pending_pkg::ST_RELEASED && ev[msg_pending_pkg::EV_STOP] && msg_count_i != 8'h00)
      |=> c_r.oe)
      else $error("stop with queued messages did not reassert");

   stop_empty_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (c_r.st == msg_pending_pkg::ST_RELEASED && ev[msg_pending_pkg::EV_STOP] && msg_count_i == 8'h00)
      |=> !c_r.oe ##1 (!c_r.oe || $past(msg_count_i) != 8'h00))
      else $error("stop with empty queue asserted alert");

   end_ident_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (msg_count_i == 8'h00) |=> (message_identifier_o == msg_pending_pkg::END_IDENT))
      else $error("empty queue did not give end identifier");

   nack_stop_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      nack_stop_s |=> (ptr_reset_o && ptr_addr_o == msg_pending_pkg::COUNT_ADDR) ##1 !ptr_reset_o)
      else $error("nack then stop did not reset pointer");

   ident_range_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      (msg_count_i != 8'h00) |=> (message_identifier_o >= msg_pending_pkg::TOUCH_ID_BASE &&
      message_identifier_o <= msg_pending_pkg::TOUCH_ID_LAST && message_identifier_o ==
      msg_pending_pkg::TOUCH_ID_BASE + {4'h0, $past(touch_idx_i)}))
      else $error("identifier outside touch range");

   never_high_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
      message_pending_n_o == 1'b0)
      else $error("alert pin level driven high");
endmodule : message_pending_signal
`default_nettype wire

// ==== host_link_model.sv ====
// Behavioural link engine and host: framed pulses on a link clock that idles between frames
`timescale 1ns/1ns
`default_nettype none
module host_link_model
(
   output var logic link_clk_o,
   output var logic id_ack_o,
   output var logic next_staged_o,
   output var logic nack_o,
   output var logic stop_o
);
   initial
   begin
      link_clk_o    = 1'b0;
      id_ack_o      = 1'b0;
      next_staged_o = 1'b0;
      nack_o        = 1'b0;
      stop_o        = 1'b0;
   end

   // One frame: event pulse over one link edge, then a quiet edge for spacing
   // Host never drives the alert pin and ignores it mid-read
   // ev bits: 0 ack, 1 staged, 2 nack, 3 stop; nack then stop ends a read
   task automatic pulse(input logic [3:0] ev);
      {stop_o, nack_o, next_staged_o, id_ack_o} = ev;
      #32 link_clk_o = 1'b1;
      #32 link_clk_o = 1'b0;
      {stop_o, nack_o, next_staged_o, id_ack_o} = 4'h0;
      #32 link_clk_o = 1'b1;
      #32 link_clk_o = 1'b0;
   endtask : pulse
endmodule : host_link_model
`default_nettype wire

// ==== message_pending_signal_tb_top.sv ====
// Self-checking bench for the alert line controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module message_pending_signal_tb_top;
   logic        mclk_i, nrst_i, lclk, ack, stg, nack, stop, pin_n, oe, prst;
   logic [7:0]  cnt_i, ident;
   logic [3:0]  idx_i;
   logic [15:0] ptr;
   int          n_mismatch, cmp_count, hits;

   host_link_model host (.link_clk_o(lclk), .id_ack_o(ack), .next_staged_o(stg), .nack_o(nack), .stop_o(stop));
   message_pending_signal DUT (.mclk_i(mclk_i), .nrst_i(nrst_i), .link_clk_i(lclk), .id_ack_i(ack),
      .next_staged_i(stg), .nack_i(nack), .stop_i(stop), .msg_count_i(cnt_i), .touch_idx_i(idx_i),
      .message_pending_n_o(pin_n), .message_pending_n_oe_o(oe), .message_identifier_o(ident),
      .ptr_addr_o(ptr), .ptr_reset_o(prst));

   initial
   begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   task automatic tally_and_finish;
      $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   // Event plus crossing settles well inside 40 controller cycles
   task automatic ev_chk(input logic [3:0] ev, input logic exp_oe);
      host.pulse(ev);
      repeat (40) @(negedge mclk_i);
      `CHK(oe, exp_oe)
      `CHK(pin_n, 1'b0)
   endtask : ev_chk

   task automatic idents;
      cnt_i = 8'h00;
      @(negedge mclk_i);
      @(negedge mclk_i);
      `CHK(ident, 8'hFF)
      cnt_i = 8'h01;
      for (int i = 0; i < 16; i++)
      begin
         idx_i = i[3:0];
         @(negedge mclk_i);
         @(negedge mclk_i);
         `CHK(ident, 8'h38 + 8'(i))
      end
   endtask : idents

   // Count drop, staging before ack, release, STOP while acked, joint ack and staging
   task automatic walk;
      cnt_i = 8'h00;
      repeat (2) @(negedge mclk_i);
      `CHK(oe, 1'b0)
      cnt_i = 8'h02;
      repeat (4) @(negedge mclk_i);
      `CHK(oe, 1'b1)
      ev_chk(4'h2, 1'b1);
      ev_chk(4'h1, 1'b1);
      ev_chk(4'h2, 1'b0);
      ev_chk(4'h8, 1'b1);
      ev_chk(4'h1, 1'b1);
      ev_chk(4'h8, 1'b1);
      ev_chk(4'h3, 1'b0);
      cnt_i = 8'h00;
      ev_chk(4'h8, 1'b0);
   endtask : walk

   // One pointer reset pulse per NACK and STOP, split or together
   task automatic ptr_rst(input logic split);
      hits = 0;
      fork
         begin
            if (split)
               host.pulse(4'h4);
            host.pulse(split ? 4'h8 : 4'hC);
         end
         repeat (140) @(negedge mclk_i) hits += int'(prst);
      join
      `CHK(hits, 1)
      `CHK(ptr, 16'h0182)
   endtask : ptr_rst

   initial
   begin
      n_mismatch = 0;
      cmp_count  = 0;
      nrst_i     = 1'b1;
      cnt_i      = 8'h00;
      idx_i      = 4'h0;
      // Drop reset after time zero so the idle link flops see the edge
      #1 nrst_i = 1'b0;
      repeat (10) @(negedge mclk_i);
      `CHK({oe, pin_n, prst}, 3'b000)
      `CHK(ptr, 16'h0182)
      nrst_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      idents();
      walk();
      ptr_rst(1'b1);
      ptr_rst(1'b0);
      tally_and_finish();
   end

   initial
   begin
      #100000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule : message_pending_signal_tb_top
`default_nettype wire
